// [smnsr_pkg.sv]
// register map, field positions and reset values of the sync and monitor register slice
// assumes a byte-wide register port with 13-bit addresses in front of it
package smnsr_pkg;

    localparam int ADDR_W   = 13;
    localparam int RW_COUNT = 12;
    localparam int RES_W    = 20;

    // read/write register offsets
    localparam logic [ADDR_W-1:0] OFS_SYNC       = 13'h0100;
    localparam logic [ADDR_W-1:0] OFS_MON_CTRL   = 13'h0112;
    localparam logic [ADDR_W-1:0] OFS_PERIOD0    = 13'h0113;
    localparam logic [ADDR_W-1:0] OFS_PERIOD1    = 13'h0114;
    localparam logic [ADDR_W-1:0] OFS_PERIOD2    = 13'h0115;
    localparam logic [ADDR_W-1:0] OFS_OSC_CTRL   = 13'h011D;
    localparam logic [ADDR_W-1:0] OFS_FREQ0      = 13'h011E;
    localparam logic [ADDR_W-1:0] OFS_FREQ1      = 13'h011F;
    localparam logic [ADDR_W-1:0] OFS_FREQ2      = 13'h0120;
    localparam logic [ADDR_W-1:0] OFS_FREQ3      = 13'h0121;
    localparam logic [ADDR_W-1:0] OFS_PHASE0     = 13'h0122;
    localparam logic [ADDR_W-1:0] OFS_PHASE1     = 13'h0123;

    // read-only result offsets
    localparam logic [ADDR_W-1:0] OFS_RES_A0     = 13'h0116;
    localparam logic [ADDR_W-1:0] OFS_RES_A1     = 13'h0117;
    localparam logic [ADDR_W-1:0] OFS_RES_A2     = 13'h0118;
    localparam logic [ADDR_W-1:0] OFS_RES_B0     = 13'h0119;
    localparam logic [ADDR_W-1:0] OFS_RES_B1     = 13'h011A;
    localparam logic [ADDR_W-1:0] OFS_RES_B2     = 13'h011B;

    // slot of each read/write register in the storage array
    localparam int IDX_SYNC     = 0;
    localparam int IDX_MON_CTRL = 1;
    localparam int IDX_PERIOD0  = 2;
    localparam int IDX_OSC_CTRL = 5;
    localparam int IDX_FREQ0    = 6;
    localparam int IDX_PHASE0   = 10;

    localparam logic [ADDR_W-1:0] RW_ADDR [RW_COUNT] = '{
        OFS_SYNC, OFS_MON_CTRL, OFS_PERIOD0, OFS_PERIOD1, OFS_PERIOD2, OFS_OSC_CTRL,
        OFS_FREQ0, OFS_FREQ1, OFS_FREQ2, OFS_FREQ3, OFS_PHASE0, OFS_PHASE1};

    localparam logic [7:0] RW_RESET [RW_COUNT] = '{
        8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam logic [23:0] PERIOD_RESET = 24'h00_0080;

    // sync gating control fields
    localparam int SYNC_MASTER_BIT  = 0;
    localparam int SYNC_HB_EN_BIT   = 5;
    localparam int SYNC_HB_ONCE_BIT = 6;
    localparam int SYNC_MON_EN_BIT  = 7;
    localparam logic [7:0] SYNC_HB_EN_MASK = 8'h20;

endpackage

// [smnsr_regs.sv]
// configuration and status registers for signal monitor, oscillator and sync gating
// assumes a byte register port decoded from the serial programming port, sample clock domain
`timescale 1ns/1ps
`default_nettype none
module smnsr_regs #(
    parameter int ADDR_W = smnsr_pkg::ADDR_W,
    parameter int RES_W  = smnsr_pkg::RES_W
) (
    input  wire logic              mclk_in,
    input  wire logic              nrst_in,
    input  wire logic [ADDR_W-1:0] reg_addr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_write_in,
    input  wire logic              reg_read_in,
    output logic      [7:0]        reg_rdata_out,
    input  wire logic [RES_W-1:0]  result_a_in,
    input  wire logic [RES_W-1:0]  result_b_in,
    input  wire logic              sync_in,
    input  wire logic              decimation_phase_in,
    output logic      [7:0]        sync_ctrl_out,
    output logic      [7:0]        monitor_ctrl_out,
    output logic      [23:0]       monitor_period_out,
    output logic      [7:0]        osc_ctrl_out,
    output logic      [31:0]       osc_freq_out,
    output logic      [15:0]       osc_phase_out,
    output logic                   monitor_sync_out,
    output logic                   hb_sync_out,
    output logic                   hb_phase_out
);

    localparam int RW_COUNT = smnsr_pkg::RW_COUNT;

    smnsr_sync_if sync_bus ();

    logic [7:0]               rw_q [RW_COUNT];
    logic [7:0]               rw_rdata;
    wire logic [7:0]          ro_rdata;
    wire logic                ro_hit;
    wire logic [7:0]          next_rdata;
    wire logic [7:0]          sync_q;

    assign sync_q = rw_q[smnsr_pkg::IDX_SYNC];

    // gate enables come from the live sync register, the sync level from sync_in
    assign sync_bus.sync_level   = sync_in;
    assign sync_bus.master_en    = sync_q[smnsr_pkg::SYNC_MASTER_BIT];
    assign sync_bus.monitor_en   = sync_q[smnsr_pkg::SYNC_MON_EN_BIT];
    assign sync_bus.hb_en        = sync_q[smnsr_pkg::SYNC_HB_EN_BIT];
    assign sync_bus.hb_next_only = sync_q[smnsr_pkg::SYNC_HB_ONCE_BIT];

    smnsr_sync_gate u_gate (
        .mclk_in   (mclk_in),
        .nrst_in   (nrst_in),
        .sync_port (sync_bus)
    );

    // read/write byte registers; a software write in the same cycle beats the self-clear
    for (genvar i = 0; i < RW_COUNT; i++) begin : g_rw
        wire logic       wr_hit;
        wire logic [7:0] clr_mask;
        assign wr_hit   = reg_write_in && (reg_addr_in == smnsr_pkg::RW_ADDR[i]);
        assign clr_mask = (i == smnsr_pkg::IDX_SYNC && sync_bus.hb_clear) ?
                          smnsr_pkg::SYNC_HB_EN_MASK : 8'h00;
        always_ff @(posedge mclk_in or negedge nrst_in) begin
            if (!nrst_in) begin
                rw_q[i] <= smnsr_pkg::RW_RESET[i];
            end else if (wr_hit) begin
                rw_q[i] <= reg_wdata_in;
            end else begin
                rw_q[i] <= rw_q[i] & ~clr_mask;
            end
        end
    end

    // read-back of the writable registers
    always_comb begin
        rw_rdata = 8'h00;
        for (int k = 0; k < RW_COUNT; k++) begin
            if (reg_addr_in == smnsr_pkg::RW_ADDR[k]) begin
                rw_rdata = rw_q[k];
            end
        end
    end

    // results: live values, unused upper nibble reads zero
    assign ro_rdata =
        (reg_addr_in == smnsr_pkg::OFS_RES_A0) ? result_a_in[7:0] :
        (reg_addr_in == smnsr_pkg::OFS_RES_A1) ? result_a_in[15:8] :
        (reg_addr_in == smnsr_pkg::OFS_RES_A2) ? {4'h0, result_a_in[19:16]} :
        (reg_addr_in == smnsr_pkg::OFS_RES_B0) ? result_b_in[7:0] :
        (reg_addr_in == smnsr_pkg::OFS_RES_B1) ? result_b_in[15:8] :
        (reg_addr_in == smnsr_pkg::OFS_RES_B2) ? {4'h0, result_b_in[19:16]} :
        8'h00;

    assign ro_hit = (reg_addr_in >= smnsr_pkg::OFS_RES_A0) &&
                    (reg_addr_in <= smnsr_pkg::OFS_RES_B2);
    assign next_rdata = ro_hit ? ro_rdata : rw_rdata;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_read_in) begin
            reg_rdata_out <= next_rdata;
        end
    end

    // gated sync pulses, registered so outputs come from flops
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            monitor_sync_out <= 1'b0;
            hb_sync_out      <= 1'b0;
            hb_phase_out     <= 1'b0;
        end else begin
            monitor_sync_out <= sync_bus.monitor_pulse;
            hb_sync_out      <= sync_bus.hb_pulse;
            if (sync_bus.hb_pulse) begin
                hb_phase_out <= decimation_phase_in;
            end
        end
    end

    assign sync_ctrl_out      = sync_q;
    assign monitor_ctrl_out   = rw_q[smnsr_pkg::IDX_MON_CTRL];
    assign monitor_period_out = {rw_q[smnsr_pkg::IDX_PERIOD0 + 2],
                                 rw_q[smnsr_pkg::IDX_PERIOD0 + 1],
                                 rw_q[smnsr_pkg::IDX_PERIOD0]};
    assign osc_ctrl_out       = rw_q[smnsr_pkg::IDX_OSC_CTRL];
    assign osc_freq_out       = {rw_q[smnsr_pkg::IDX_FREQ0 + 3], rw_q[smnsr_pkg::IDX_FREQ0 + 2],
                                 rw_q[smnsr_pkg::IDX_FREQ0 + 1], rw_q[smnsr_pkg::IDX_FREQ0]};
    assign osc_phase_out      = {rw_q[smnsr_pkg::IDX_PHASE0 + 1], rw_q[smnsr_pkg::IDX_PHASE0]};

    // checks
    wire logic sync_wr;
    assign sync_wr = reg_write_in && (reg_addr_in == smnsr_pkg::OFS_SYNC);

    monitor_sync_fwd_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        sync_in && !$past(sync_in) && sync_q[7] && sync_q[0] |=> monitor_sync_out)
        else $error("monitor sync not forwarded");

    monitor_sync_gate_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !(sync_q[7] && sync_q[0]) |=> !monitor_sync_out)
        else $error("monitor sync passed while gated");

    master_gate_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !sync_q[0] |=> !monitor_sync_out && !hb_sync_out)
        else $error("sync passed without master enable");

    hb_once_clear_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        hb_sync_out && $past(sync_q[6]) && !$past(sync_wr) |-> !sync_q[5])
        else $error("half-band enable not cleared after single sync");

    // a rewrite of the enable right after the single sync may legally re-arm it
    hb_once_ignore_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        hb_sync_out && $past(sync_q[6]) && !$past(sync_wr) && !sync_wr
        |-> ##2 !hb_sync_out)
        else $error("later sync pulse reached half-band");

    hb_restart_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        sync_in && !$past(sync_in) && sync_q[5] && sync_q[0]
        |=> hb_sync_out && hb_phase_out == $past(decimation_phase_in))
        else $error("half-band not restarted at chosen phase");

    sync_edge_only_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        sync_in && $past(sync_in) |=> !monitor_sync_out && !hb_sync_out)
        else $error("sync level treated as repeated pulse");

    period_reset_a: assert property (@(posedge mclk_in)
        $rose(nrst_in) |-> monitor_period_out == smnsr_pkg::PERIOD_RESET)
        else $error("period reset value wrong");

    result_a_read_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_RES_A2
        |=> reg_rdata_out == {4'h0, $past(result_a_in[19:16])})
        else $error("channel A top result byte wrong");

    result_b_read_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_RES_B1
        |=> reg_rdata_out == $past(result_b_in[15:8]))
        else $error("channel B middle result byte wrong");

    freq_top_byte_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_write_in && reg_addr_in == smnsr_pkg::OFS_FREQ3
        |=> osc_freq_out[31:24] == $past(reg_wdata_in))
        else $error("frequency top byte not stored");

    freq_low_byte_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_write_in && reg_addr_in == smnsr_pkg::OFS_FREQ0
        |=> osc_freq_out[7:0] == $past(reg_wdata_in))
        else $error("frequency low byte not stored");

    period_low_read_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_PERIOD0
        |=> reg_rdata_out == $past(monitor_period_out[7:0]))
        else $error("period low byte read wrong");

    period_mid_write_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_write_in && reg_addr_in == smnsr_pkg::OFS_PERIOD1
        |=> monitor_period_out[15:8] == $past(reg_wdata_in))
        else $error("period middle byte not stored");

    period_top_read_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_PERIOD2
        |=> reg_rdata_out == $past(monitor_period_out[23:16]))
        else $error("period top byte read wrong");

    result_a_low_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_RES_A0
        |=> reg_rdata_out == $past(result_a_in[7:0]))
        else $error("channel A low result byte wrong");

    result_b_top_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_RES_B2
        |=> reg_rdata_out == {4'h0, $past(result_b_in[19:16])})
        else $error("channel B top result byte wrong");

    // result slots are read only, a write there must leave the monitor control, period and frequency bytes alone
    result_write_refused_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_write_in && ro_hit
        |=> $stable(monitor_ctrl_out) && $stable(monitor_period_out) && $stable(osc_freq_out))
        else $error("write to result register changed storage");

    hb_gate_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !(sync_bus.hb_en && sync_bus.master_en)
        |=> !hb_sync_out)
        else $error("half-band sync passed while gated");

    hb_self_clear_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        sync_bus.hb_clear && !sync_wr
        |=> !sync_bus.hb_en)
        else $error("half-band enable survived single sync");

    monitor_pulse_once_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        monitor_sync_out
        |=> !monitor_sync_out)
        else $error("monitor sync pulse longer than one cycle");

    hb_pulse_once_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        hb_sync_out
        |=> !hb_sync_out)
        else $error("half-band sync pulse longer than one cycle");

    // the captured phase may only move together with a restart pulse
    hb_phase_hold_a: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !hb_sync_out
        |-> $stable(hb_phase_out))
        else $error("half-band phase moved without restart");

    monitor_sync_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        monitor_sync_out);

    hb_single_sync_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        hb_sync_out && $past(sync_q[6]));

    result_read_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        reg_read_in && reg_addr_in == smnsr_pkg::OFS_RES_B2);

    hb_continuous_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        hb_sync_out && !$past(sync_q[6]));

    master_blocked_c: cover property (@(posedge mclk_in) disable iff (!nrst_in)
        sync_bus.edge_seen && !sync_bus.master_en);

endmodule
`default_nettype wire

// [smnsr_sync_gate.sv]
// edge detection of the external sync input and gating toward monitor and half-band
// assumes the sync level is already synchronous to mclk_in
`timescale 1ns/1ps
`default_nettype none
module smnsr_sync_gate (
    input  wire logic   mclk_in,
    input  wire logic   nrst_in,
    smnsr_sync_if.gate  sync_port
);

    logic sync_prev;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= sync_port.sync_level;
        end
    end

    // one pulse per rising edge of sync
    assign sync_port.edge_seen     = sync_port.sync_level & ~sync_prev;
    assign sync_port.monitor_pulse = sync_port.edge_seen & sync_port.master_en
                                   & sync_port.monitor_en;
    assign sync_port.hb_pulse      = sync_port.edge_seen & sync_port.master_en
                                   & sync_port.hb_en;
    assign sync_port.hb_clear      = sync_port.hb_pulse & sync_port.hb_next_only;

endmodule
`default_nettype wire

// [smnsr_sync_if.sv]
// sync gating signals passed between the register slice and its gate
// assumes both ends run on the same sample clock
`timescale 1ns/1ps
`default_nettype none
interface smnsr_sync_if;
    logic sync_level;
    logic master_en;
    logic monitor_en;
    logic hb_en;
    logic hb_next_only;
    logic edge_seen;
    logic monitor_pulse;
    logic hb_pulse;
    logic hb_clear;

    modport gate (
        input  sync_level,
        input  master_en,
        input  monitor_en,
        input  hb_en,
        input  hb_next_only,
        output edge_seen,
        output monitor_pulse,
        output hb_pulse,
        output hb_clear
    );

    modport regs (
        output sync_level,
        output master_en,
        output monitor_en,
        output hb_en,
        output hb_next_only,
        input  edge_seen,
        input  monitor_pulse,
        input  hb_pulse,
        input  hb_clear
    );
endinterface
`default_nettype wire

// [tb_signal_monitor_nco_sync_regs.sv]
// self-checking bench for the sync gating and monitor register slice
// assumes smnsr_pkg, smnsr_sync_if, smnsr_sync_gate and smnsr_regs are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_signal_monitor_nco_sync_regs;
    typedef struct {
        int          due;
        int          sel;
        logic [31:0] exp;
        string       name;
    } smnsr_note_type;

    localparam int AW = smnsr_pkg::ADDR_W;
    localparam int FQ = smnsr_pkg::IDX_FREQ0;
    localparam int PD = smnsr_pkg::IDX_PERIOD0;
    // control value, expected {mon1, hb1, mon2, hb2}, control value afterwards
    localparam logic [23:0] SYNC_TBL [6] = '{24'h80_0080, 24'h81_0A81, 24'h21_0521,
                                             24'h60_0060, 24'hE1_0EC1, 24'h61_0441};

    logic          mclk_in             = 1'b0;
    logic          nrst_in             = 1'b0;
    logic [AW-1:0] reg_addr_in         = '0;
    logic [7:0]    reg_wdata_in        = 8'h00;
    logic          reg_write_in        = 1'b0;
    logic          reg_read_in         = 1'b0;
    logic [19:0]   result_a_in         = 20'h0_0000;
    logic [19:0]   result_b_in         = 20'h0_0000;
    logic          sync_in             = 1'b0;
    logic          decimation_phase_in = 1'b0;
    logic [7:0]    reg_rdata_out;
    logic [7:0]    sync_ctrl_out;
    logic [7:0]    monitor_ctrl_out;
    logic [23:0]   monitor_period_out;
    logic [7:0]    osc_ctrl_out;
    logic [31:0]   osc_freq_out;
    logic [15:0]   osc_phase_out;
    logic          monitor_sync_out;
    logic          hb_sync_out;
    logic          hb_phase_out;
    logic [31:0]   got;
    smnsr_note_type notes [$];
    int            cyc         = 0;
    int            miscompares = 0;
    int            checks_done = 0;

    smnsr_regs DUT (
        .mclk_in(mclk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
        .reg_rdata_out(reg_rdata_out), .result_a_in(result_a_in), .result_b_in(result_b_in),
        .sync_in(sync_in), .decimation_phase_in(decimation_phase_in),
        .sync_ctrl_out(sync_ctrl_out), .monitor_ctrl_out(monitor_ctrl_out),
        .monitor_period_out(monitor_period_out), .osc_ctrl_out(osc_ctrl_out),
        .osc_freq_out(osc_freq_out), .osc_phase_out(osc_phase_out),
        .monitor_sync_out(monitor_sync_out), .hb_sync_out(hb_sync_out),
        .hb_phase_out(hb_phase_out)
    );

    always #20 mclk_in = ~mclk_in;

    always @(posedge mclk_in) cyc <= cyc + 1;

    function automatic logic [31:0] seen(input int s);
        case (s)
            0:       seen = {24'h00_0000, reg_rdata_out};
            1:       seen = {31'h0000_0000, monitor_sync_out};
            2:       seen = {31'h0000_0000, hb_sync_out};
            3:       seen = {31'h0000_0000, hb_phase_out};
            4:       seen = {24'h00_0000, sync_ctrl_out};
            5:       seen = osc_freq_out;
            6:       seen = {8'h00, monitor_period_out};
            7:       seen = {24'h00_0000, monitor_ctrl_out};
            8:       seen = {24'h00_0000, osc_ctrl_out};
            default: seen = {16'h0000, osc_phase_out};
        endcase
    endfunction

    // compares each note in the cycle it falls due
    always @(negedge mclk_in) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            got = seen(notes[0].sel);
            checks_done++;
            if (got !== notes[0].exp) begin
                miscompares++;
                $display("BAD %s expected %h seen %h", notes[0].name, notes[0].exp, got);
            end
            void'(notes.pop_front());
        end
    end

    task automatic note(input int sel, input logic [31:0] exp, input int dly, input string nm);
        notes.push_back('{cyc + dly, sel, exp, nm});
    endtask

    // drives one cycle of the register port, called at a falling edge
    task automatic op(input logic w, input logic r, input logic [AW-1:0] a, input logic [7:0] d);
        reg_write_in = w;
        reg_read_in  = r;
        reg_addr_in  = a;
        reg_wdata_in = d;
        @(negedge mclk_in);
    endtask

    task automatic idle();
        op(1'b0, 1'b0, '0, 8'h00);
    endtask

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        op(1'b1, 1'b0, a, d);
    endtask

    task automatic rd(input logic [AW-1:0] a, input logic [7:0] exp, input logic w,
                      input logic [7:0] d, input string nm);
        note(0, {24'h00_0000, exp}, 1, nm);
        op(w, 1'b1, a, d);
    endtask

    // one rising sync edge, held high a second cycle, then released
    task automatic pulse(input logic m, input logic h);
        logic ph;
        ph = 1'($urandom());
        decimation_phase_in = ph;
        note(1, {31'h0000_0000, m}, 1, "monitor pulse");
        note(2, {31'h0000_0000, h}, 1, "hb pulse");
        if (h) note(3, {31'h0000_0000, ph}, 1, "hb phase");
        sync_in = 1'b1;
        idle();
        note(1, 32'h0000_0000, 1, "monitor pulse");
        note(2, 32'h0000_0000, 1, "hb pulse");
        idle();
        sync_in = 1'b0;
        idle();
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin : watchdog
        #(5000 * 40);
        miscompares++;
        conclude();
    end

    initial begin : main
        logic [7:0]  vals [12];
        logic [31:0] r;
        logic [23:0] t;
        int          i;
        void'($urandom(32'h1866));
        repeat (16) @(negedge mclk_in);
        nrst_in = 1'b1;
        @(negedge mclk_in);
        for (i = 0; i < 12; i++) begin
            rd(smnsr_pkg::RW_ADDR[i], smnsr_pkg::RW_RESET[i], 1'b0, 8'h00, "reset");
        end
        note(6, {8'h00, smnsr_pkg::PERIOD_RESET}, 1, "period");
        idle();
        for (i = 0; i < 12; i++) begin
            vals[i] = 8'($urandom());
            wr(smnsr_pkg::RW_ADDR[i], vals[i]);
        end
        for (i = 0; i < 12; i++) begin
            rd(smnsr_pkg::RW_ADDR[i], vals[i], 1'b0, 8'h00, "readback");
        end
        note(5, {vals[FQ+3], vals[FQ+2], vals[FQ+1], vals[FQ]}, 1, "freq");
        note(6, {8'h00, vals[PD+2], vals[PD+1], vals[PD]}, 1, "period");
        note(8, {24'h00_0000, vals[smnsr_pkg::IDX_OSC_CTRL]}, 1, "osc ctrl");
        note(9, {16'h0000, vals[smnsr_pkg::IDX_PHASE0 + 1], vals[smnsr_pkg::IDX_PHASE0]}, 1,
             "phase");
        rd(smnsr_pkg::OFS_MON_CTRL, vals[1], 1'b1, ~vals[1], "read old");
        note(7, {24'h00_0000, ~vals[1]}, 1, "mon ctrl");
        rd(smnsr_pkg::OFS_MON_CTRL, ~vals[1], 1'b0, 8'h00, "read new");
        result_a_in = 20'($urandom());
        result_b_in = 20'($urandom());
        for (i = 0; i < 6; i++) begin
            r = {12'h000, (i < 3) ? result_a_in : result_b_in};
            wr(13'(smnsr_pkg::OFS_RES_A0 + i), 8'hFF);
            rd(13'(smnsr_pkg::OFS_RES_A0 + i), 8'(r >> (8 * (i % 3))), 1'b0, 8'h00,
               "result");
        end
        wr(13'h011C, 8'h5A);
        rd(13'h011C, 8'h00, 1'b0, 8'h00, "unmapped");
        for (i = 0; i < 6; i++) begin
            t = SYNC_TBL[i];
            wr(smnsr_pkg::OFS_SYNC, t[23:16]);
            pulse(t[11], t[10]);
            pulse(t[9], t[8]);
            note(4, {24'h00_0000, t[7:0]}, 1, "sync ctrl");
            idle();
        end
        repeat (3) idle();
        // reset again in mid-run: stored values must fall back to their reset values
        nrst_in = 1'b0;
        repeat (2) idle();
        nrst_in = 1'b1;
        note(4, 32'h0000_0000, 1, "sync ctrl reset");
        note(6, {8'h00, smnsr_pkg::PERIOD_RESET}, 1, "period reset");
        note(8, 32'h0000_0000, 1, "osc ctrl reset");
        repeat (3) idle();
        conclude();
    end
endmodule
`default_nettype wire
